// File: three_wire_config_port.sv
// serial slave port, byte register bank, init and power-up control
// assumes serial pins are synchronous to clk and slow against it
//
// Operation
// - init bit self-clears; outputs held low meanwhile
// - sysref delay writes apply without init
// - transfers are whole 8-bit units
// - select high: pin released, clock ignored
// - input bits sampled on rising serial clock
// - read data changes on edge per selection
// - select low enables port, pin input
// - first byte: direction bit, seven address
// - fields shifted least significant bit first
// - read: drive pin, load register, shift
// - continued read presents next register each byte
// - write payload committed at byte end
// - write address increments after each byte
// - power-up flag in status bit one
//
// The address-and-strobe port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module three_wire_config_port #(
    parameter int POWERUP_CYCLES = three_wire_pkg::POWERUP_CYCLES,
    parameter int INIT_CYCLES    = three_wire_pkg::INIT_CYCLES
) (
    // clock and reset
    input  wire logic                    clk,
    input  wire logic                    rst_b,
    // serial pins
    input  wire logic                    sclk,
    input  wire logic                    serial_select_low,
    input  wire logic                    serial_data_pin_in,
    output var  logic                    serial_data_pin_out,
    output var  logic                    serial_data_pin_oe,
    // local register port
    input  wire logic [6:0]              bus_addr,
    input  wire logic [7:0]              bus_wdata,
    input  wire logic                    bus_wr,
    input  wire logic                    bus_rd,
    output var  logic [7:0]              bus_rdata,
    // device control
    output var  logic                    clock_outputs_low,
    output var  logic                    sysref_outputs_low,
    output var  logic                    divider_restart,
    output var  logic                    powerup_done_flag,
    output var  three_wire_pkg::reg_write_type reg_write
);

    localparam int PW = $clog2(POWERUP_CYCLES + 1);
    localparam int IW = $clog2(INIT_CYCLES + 1);
    // ========================================
    // register bank
    logic [7:0] mem [0:127];
    logic       init_busy_r;
    logic       powerup_done_r;
    // reads hide locked space and show live status bits
    function automatic logic [7:0] read_reg(input logic [6:0] a);
        logic [7:0] v;
        v = mem[a];
        if (a >= three_wire_pkg::LOCKED_BASE) begin
            v = 8'h00;
        end
        if (a == three_wire_pkg::CTRL_ADDR) begin
            v[three_wire_pkg::INIT_BIT] = init_busy_r;
        end
        if (a == three_wire_pkg::STATUS_ADDR) begin
            v = 8'h00;
            v[three_wire_pkg::READY_BIT] = powerup_done_r;
        end
        return v;
    endfunction : read_reg
    wire logic read_edge =
        mem[three_wire_pkg::CTRL_ADDR][three_wire_pkg::READ_EDGE_BIT];

    // ========================================
    // serial port
    three_wire_pkg::port_state_type state_r, state_nxt;
    logic [2:0] cnt_r,   cnt_nxt;
    logic [7:0] in_r,    in_nxt;
    logic [7:0] sh_r,    sh_nxt;
    logic [6:0] addr_r,  addr_nxt;
    logic       dout_r,  dout_nxt;
    logic       oe_r,    oe_nxt;
    logic       sclk_r;
    logic       rise;
    logic       fall;
    logic       spi_we;
    logic [7:0] byte_in;
    // edges of the sampled serial clock
    assign rise    = sclk & ~sclk_r;
    assign fall    = ~sclk & sclk_r;
    assign byte_in = {serial_data_pin_in, in_r[7:1]};
    // shift engine next state
    always_comb begin
        logic       load;
        logic [6:0] ra;
        logic [7:0] rv;
        load      = 1'b0;
        ra        = addr_r;
        rv        = 8'h00;
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        in_nxt    = in_r;
        sh_nxt    = sh_r;
        addr_nxt  = addr_r;
        dout_nxt  = dout_r;
        oe_nxt    = oe_r;
        spi_we    = 1'b0;
        if (serial_select_low) begin
            state_nxt = three_wire_pkg::ST_IDLE;
            cnt_nxt   = 3'h0;
            oe_nxt    = 1'b0;
        end else begin
            if (state_r == three_wire_pkg::ST_IDLE) begin
                state_nxt = three_wire_pkg::ST_CMD;
            end
            if (rise) begin
                in_nxt  = byte_in;
                cnt_nxt = 3'(cnt_r + 3'h1);
                // every action falls on a byte boundary
                if (cnt_r == 3'h7) begin
                    case (state_r)
                        three_wire_pkg::ST_IDLE,
                        three_wire_pkg::ST_CMD: begin
                            if (byte_in[0]) begin
                                state_nxt = three_wire_pkg::ST_RD;
                                oe_nxt    = 1'b1;
                                load      = 1'b1;
                                ra        = byte_in[7:1];
                            end else begin
                                state_nxt = three_wire_pkg::ST_WR;
                                addr_nxt  = byte_in[7:1];
                            end
                        end
                        three_wire_pkg::ST_RD: begin
                            load = 1'b1;
                        end
                        three_wire_pkg::ST_WR: begin
                            spi_we   = 1'b1;
                            addr_nxt = 7'(addr_r + 7'h01);
                        end
                        default: begin
                            state_nxt = three_wire_pkg::ST_IDLE;
                        end
                    endcase
                end
            end
            if (load) begin
                rv       = read_reg(ra);
                addr_nxt = 7'(ra + 7'h01);
                if (read_edge) begin
                    dout_nxt = rv[0];
                    sh_nxt   = {1'b0, rv[7:1]};
                end else begin
                    sh_nxt = rv;
                end
            end else if (state_r == three_wire_pkg::ST_RD &&
                         (read_edge ? rise : fall)) begin
                // output changes on the chosen edge
                dout_nxt = sh_r[0];
                sh_nxt   = {1'b0, sh_r[7:1]};
            end
        end
    end
    // shift engine registers
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= three_wire_pkg::ST_IDLE;
            cnt_r   <= 3'h0;
            in_r    <= 8'h00;
            sh_r    <= 8'h00;
            addr_r  <= 7'h00;
            dout_r  <= 1'b0;
            oe_r    <= 1'b0;
            sclk_r  <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            in_r    <= in_nxt;
            sh_r    <= sh_nxt;
            addr_r  <= addr_nxt;
            dout_r  <= dout_nxt;
            oe_r    <= oe_nxt;
            sclk_r  <= sclk;
        end
    end
    assign serial_data_pin_out = dout_r;
    assign serial_data_pin_oe  = oe_r;
    // ========================================
    // write commit, local reads
    three_wire_pkg::reg_write_type wr_r, wr_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic       store;
    // serial writes win; a colliding local write is dropped
    always_comb begin
        wr_nxt = '0;
        if (spi_we) begin
            wr_nxt = {1'b1, addr_r, byte_in};
        end else if (bus_wr) begin
            wr_nxt = {1'b1, bus_addr, bus_wdata};
        end
        // plain store; only a CTRL_ADDR write with the init bit set pauses or restarts
        store     = wr_nxt.valid && wr_nxt.addr < three_wire_pkg::LOCKED_BASE;
        rdata_nxt = bus_rd ? read_reg(bus_addr) : 8'h00;
    end
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_r    <= '0;
            rdata_r <= 8'h00;
            for (int i = 0; i < 128; i++) begin
                mem[i] <= three_wire_pkg::REG_RESET;
            end
        end else begin
            wr_r    <= wr_nxt;
            rdata_r <= rdata_nxt;
            if (store) begin
                mem[wr_nxt.addr] <= wr_nxt.data;
            end
        end
    end
    assign reg_write = wr_r;
    assign bus_rdata = rdata_r;

    // ========================================
    // divider init and power-up
    logic [IW-1:0] icnt_r, icnt_nxt;
    logic [PW-1:0] pcnt_r, pcnt_nxt;
    logic          busy_nxt;
    logic          low_r, low_nxt;
    logic          rst_pulse_r, rst_pulse_nxt;
    logic          done_nxt;
    logic          init_start;
    always_comb begin
        init_start = wr_nxt.valid &&
                     wr_nxt.addr == three_wire_pkg::CTRL_ADDR &&
                     wr_nxt.data[three_wire_pkg::INIT_BIT];
        busy_nxt      = init_busy_r;
        icnt_nxt      = icnt_r;
        rst_pulse_nxt = 1'b0;
        // self-clearing init, a new set wins
        if (init_start) begin
            busy_nxt = 1'b1;
            icnt_nxt = IW'(INIT_CYCLES - 1);
        end else if (init_busy_r) begin
            if (icnt_r == '0) begin
                busy_nxt      = 1'b0;
                rst_pulse_nxt = 1'b1;
            end else begin
                icnt_nxt = IW'(icnt_r - 1'b1);
            end
        end
        low_nxt  = busy_nxt;
        // flag set once internal start-up ends
        done_nxt = powerup_done_r || pcnt_r == PW'(POWERUP_CYCLES - 1);
        pcnt_nxt = done_nxt ? pcnt_r : PW'(pcnt_r + 1'b1);
    end
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            init_busy_r    <= 1'b0;
            icnt_r         <= '0;
            low_r          <= 1'b0;
            rst_pulse_r    <= 1'b0;
            pcnt_r         <= '0;
            powerup_done_r <= 1'b0;
        end else begin
            init_busy_r    <= busy_nxt;
            icnt_r         <= icnt_nxt;
            low_r          <= low_nxt;
            rst_pulse_r    <= rst_pulse_nxt;
            pcnt_r         <= pcnt_nxt;
            powerup_done_r <= done_nxt;
        end
    end
    // all dividers restart together as outputs are released
    assign clock_outputs_low  = low_r;
    assign sysref_outputs_low = low_r;
    assign divider_restart    = rst_pulse_r;
    assign powerup_done_flag  = powerup_done_r;

    // ========================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence byte_end_s;
        !serial_select_low && rise && cnt_r == 3'h7;
    endsequence
    sequence cmd_rd_s;
        byte_end_s ##0 state_r == three_wire_pkg::ST_CMD && byte_in[0];
    endsequence
    select_idle_a: assert property (
        serial_select_low |=> !serial_data_pin_oe)
        else $error("pin driven while deselected");
    phase_reset_a: assert property (
        serial_select_low |=> state_r == three_wire_pkg::ST_IDLE && cnt_r == '0)
        else $error("phase not reset");
    read_turn_a: assert property (
        cmd_rd_s |=> serial_data_pin_oe
            && addr_r == $past(byte_in[7:1]) + 7'h01)
        else $error("read turnaround missing");
    write_commit_a: assert property (
        byte_end_s ##0 state_r == three_wire_pkg::ST_WR
        |=> reg_write.valid && reg_write.data == $past(byte_in)
            && addr_r == $past(addr_r) + 7'h01)
        else $error("write byte not committed");
    edge_hold_a: assert property (
        state_r == three_wire_pkg::ST_RD && !serial_select_low && !rise
        && !read_edge && !fall |=> $stable(serial_data_pin_out))
        else $error("read data moved off edge");
    init_low_a: assert property (
        $rose(init_busy_r) |-> clock_outputs_low ##[1:64] !init_busy_r)
        else $error("init did not clear");
    sysref_free_a: assert property (
        !init_busy_r && !init_start |=> !sysref_outputs_low)
        else $error("outputs stopped without init");
    ready_read_a: assert property (
        bus_rd && bus_addr == three_wire_pkg::STATUS_ADDR
        |=> bus_rdata[three_wire_pkg::READY_BIT] == $past(powerup_done_r))
        else $error("status flag misread");
endmodule : three_wire_config_port

`default_nettype wire

// File: three_wire_pkg.sv
// constants and types for the three-wire configuration port
// assumes one 125 MHz clock; serial pins arrive synchronous to it
`default_nettype none
package three_wire_pkg;

    // ========================================
    // timing
    localparam int CLK_PERIOD_NS   = 8;
    localparam int POWERUP_TIME_NS = 2000000;
    localparam int POWERUP_CYCLES  =
        (POWERUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int INIT_CYCLES     = 16;

    // ========================================
    // widths
    localparam int BYTE_BITS = 8;
    localparam int ADDR_BITS = 7;

    // ========================================
    // register map
    localparam logic [6:0] CTRL_ADDR   = 7'h6C;
    localparam logic [6:0] STATUS_ADDR = 7'h6E;
    localparam logic [6:0] LOCKED_BASE = 7'h78;
    localparam int         INIT_BIT      = 0;
    localparam int         READ_EDGE_BIT = 7;
    localparam int         READY_BIT     = 1;
    localparam logic [7:0] REG_RESET     = 8'h00;

    // ========================================
    // types
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_CMD  = 4'h2,
        ST_RD   = 4'h4,
        ST_WR   = 4'h8
    } port_state_type;

    typedef struct packed {
        logic       valid;
        logic [6:0] addr;
        logic [7:0] data;
    } reg_write_type;

endpackage : three_wire_pkg
`default_nettype wire

// File: spi_host_model.sv
// host master model driving the three-wire configuration port
// assumes a 125 MHz clk; serial clock made at clk/8 in frames, still between frames except while stray pulses it
`timescale 1ns/1ps
`default_nettype none

module spi_host_model (
    // clock
    input  wire logic clk,
    // serial pins
    output var  logic sclk,
    output var  logic sel_low,
    output var  logic host_data,
    input  wire logic pin
);
    // ========================================
    // idle: clock low, select high
    initial begin
        sclk      = 1'b0;
        sel_low   = 1'b1;
        host_data = 1'b0;
    end

    task automatic open_frame();
        @(posedge clk);
        sel_low <= 1'b0;
        repeat (4) @(posedge clk);
    endtask : open_frame

    // close after a fall; released line flips so stale data never passes
    task automatic close_frame();
        repeat (4) @(posedge clk);
        sel_low   <= 1'b1;
        host_data <= ~host_data;
        repeat (4) @(posedge clk);
    endtask : close_frame

    // lsb first; pin sampled just before each rise
    task automatic shift(input logic [7:0] tx, input logic drive,
                         input int n, output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 0; i < n; i++) begin
            host_data <= drive ? tx[i] : ~host_data;
            repeat (3) @(posedge clk);
            @(negedge clk) rx[i] = pin;
            @(posedge clk);
            sclk <= 1'b1;
            repeat (4) @(posedge clk);
            sclk <= 1'b0;
        end
    endtask : shift

    // clock pulses while deselected, to be ignored
    task automatic stray(input int n);
        repeat (n) begin
            @(posedge clk) sclk <= 1'b1;
            host_data <= ~host_data;
            repeat (3) @(posedge clk);
            sclk <= 1'b0;
            repeat (3) @(posedge clk);
        end
    endtask : stray
endmodule : spi_host_model
`default_nettype wire

// File: tb_three_wire_config_port.sv
// testbench for the three-wire configuration port
// assumes spi_host_model as far side and the package compiled first
`timescale 1ns/1ps
`default_nettype none

module tb_three_wire_config_port;
    // short power-up count keeps the run brief
    localparam int PU = 50;
    localparam int IC = 16;
    logic clk = 1'b0, rst_b = 1'b0, sclk, sel_low, host_data;
    logic pin_out, oe, lo_clk, lo_ref, restart, ready, bus_wr, bus_rd;
    logic [6:0] bus_addr;
    logic [7:0] bus_wdata, bus_rdata, rd;
    three_wire_pkg::reg_write_type reg_write, wr_last;
    int n_fail = 0, n_checks = 0, wr_cnt = 0, lo_cnt = 0, rs_cnt = 0;
    int pair_bad = 0, stray_oe = 0, lo0, rs0, w0;
    logic sel_d1, sel_d2;
    wire pin_w = oe ? pin_out : host_data;

    // ========================================
    // clock, design and far side
    always #4 clk = ~clk;
    initial {bus_wr, bus_rd, bus_addr, bus_wdata} = '0;
    three_wire_config_port #(.POWERUP_CYCLES(PU), .INIT_CYCLES(IC))
        three_wire_config_port_i (.clk(clk), .rst_b(rst_b), .sclk(sclk),
        .serial_select_low(sel_low), .serial_data_pin_in(pin_w),
        .serial_data_pin_out(pin_out), .serial_data_pin_oe(oe),
        .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
        .bus_rd(bus_rd), .bus_rdata(bus_rdata), .clock_outputs_low(lo_clk),
        .sysref_outputs_low(lo_ref), .divider_restart(restart),
        .powerup_done_flag(ready), .reg_write(reg_write));
    spi_host_model spi_host_model_i (.clk(clk), .sclk(sclk),
        .sel_low(sel_low), .host_data(host_data), .pin(pin_w));

    // monitors on pre-edge values of registered outputs
    always @(posedge clk) begin
        sel_d1 <= sel_low;
        sel_d2 <= sel_d1;
        if (reg_write.valid === 1'b1) begin
            wr_cnt++;
            wr_last <= reg_write;
        end
        if (lo_clk === 1'b1) lo_cnt++;
        if (lo_clk !== lo_ref) pair_bad++;
        if (restart === 1'b1) rs_cnt++;
        if (oe !== 1'b0 && sel_low && sel_d1 && sel_d2) stray_oe++;
    end

    // ========================================
    // shared tasks
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : check

    task automatic final_report();
        if (n_fail == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : final_report

    task automatic bus_write(input logic [6:0] a, input logic [7:0] d);
        @(posedge clk);
        {bus_wr, bus_addr, bus_wdata} <= {1'b1, a, d};
        @(posedge clk);
        bus_wr <= 1'b0;
    endtask : bus_write

    // read data stands only in the cycle after the strobe
    task automatic bus_read(input logic [6:0] a, output logic [7:0] d);
        @(posedge clk);
        {bus_rd, bus_addr} <= {1'b1, a};
        @(posedge clk);
        bus_rd <= 1'b0;
        @(negedge clk) d = bus_rdata;
    endtask : bus_read

    function automatic logic [7:0] pat(logic [7:0] d0, int i);
        return 8'(d0 + i * 8'h35);
    endfunction : pat

    // command byte then n bytes, always below the locked range
    task automatic spi_wr(input logic [6:0] a, input logic [7:0] d0,
                          input int n);
        logic [7:0] x;
        spi_host_model_i.open_frame();
        spi_host_model_i.shift({a, 1'b0}, 1'b1, 8, x);
        for (int i = 0; i < n; i++)
            spi_host_model_i.shift(pat(d0, i), 1'b1, 8, x);
        spi_host_model_i.close_frame();
    endtask : spi_wr

    task automatic spi_rd(input logic [6:0] a, input logic [7:0] d0,
                          input int n);
        logic [7:0] x;
        spi_host_model_i.open_frame();
        spi_host_model_i.shift({a, 1'b1}, 1'b1, 8, x);
        for (int i = 0; i < n; i++) begin
            spi_host_model_i.shift(8'h00, 1'b0, 8, x);
            check(x, pat(d0, i));
        end
        spi_host_model_i.close_frame();
    endtask : spi_rd

    // ========================================
    // tests
    initial begin
        repeat (4) @(posedge clk);
        check({oe, lo_clk, ready, bus_rdata}, 16'h0000);
        rst_b <= 1'b1;
        repeat (PU - 5) @(posedge clk);
        check(ready, 1'b0);
        repeat (10) @(posedge clk);
        check(ready, 1'b1);
        spi_rd(7'h6E, 8'h02, 1);
        spi_wr(7'h6C, 8'h00, 1);
        w0 = wr_cnt;
        spi_wr(7'h20, 8'h13, 3);
        check(16'(wr_cnt - w0), 16'h0003);
        check({wr_last.addr, wr_last.data}, {7'h22, pat(8'h13, 2)});
        for (int i = 0; i < 3; i++) begin
            bus_read(7'(7'h20 + i), rd);
            check(rd, pat(8'h13, i));
        end
        for (int e = 0; e < 2; e++) begin
            spi_wr(7'h6C, {e[0], 7'h00}, 1);
            spi_rd(7'h20, 8'h13, 3);
        end
        // deselected clocking is ignored
        w0 = wr_cnt;
        spi_host_model_i.stray(12);
        check(16'(wr_cnt - w0), 16'h0000);
        check(16'(stray_oe), 16'h0000);
        // aborted frame restarts with a command byte
        spi_host_model_i.open_frame();
        spi_host_model_i.shift(8'hFF, 1'b1, 3, rd);
        spi_host_model_i.close_frame();
        spi_wr(7'h30, 8'h5A, 1);
        bus_read(7'h30, rd);
        check(rd, 8'h5A);
        // sysref delay applies without output stop
        lo0 = lo_cnt;
        spi_wr(7'h28, 8'h07, 1);
        bus_read(7'h28, rd);
        check({rd, 8'(lo_cnt - lo0)}, 16'h0700);
        // divider and delay first, then init
        spi_wr(7'h74, 8'h00, 1);
        spi_wr(7'h20, 8'h04, 2);
        lo0 = lo_cnt;
        rs0 = rs_cnt;
        spi_wr(7'h6C, 8'h01, 1);
        repeat (IC + 10) @(posedge clk);
        check(lo_cnt - lo0 >= IC && lo_cnt - lo0 <= IC + 2, 1'b1);
        check(16'(rs_cnt - rs0), 16'h0001);
        check(16'(pair_bad), 16'h0000);
        bus_read(7'h6C, rd);
        check(rd[0], 1'b0);
        // outputs back on once init has been set
        spi_wr(7'h74, 8'hFF, 1);
        bus_read(7'h74, rd);
        check(rd, 8'hFF);
        // locked place stores nothing
        bus_write(7'h78, 8'hC3);
        bus_read(7'h78, rd);
        check(rd, 8'h00);
        final_report();
    end

    // watchdog well beyond the expected run
    initial begin
        repeat (40000) @(posedge clk);
        n_fail++;
        final_report();
    end
endmodule : tb_three_wire_config_port
`default_nettype wire
